// >>> home_search_mode2_config_tb_top.sv
// home_search_mode2_config_tb_top.sv: self-checking bench for hsm2_top
// assumes: hsm2_defs.svh, hsm2_pkg and hsm2_sensor_model compiled first
`timescale 1ns/100ps
`default_nettype none
`include "hsm2_defs.svh"

module home_search_mode2_config_tb_top;
  logic mclk, reset, hsel, hwrite, hreadyout, hresp, pol;
  logic home, zph, dev_clr, real_clr, logic_clr, busy;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [23:0] width_seen;
  int failures, checked, clr_cnt, n, k;

  hsm2_top #(
    .CLR_CYC4(20), .CLR_CYC5(21), .CLR_CYC6(22), .CLR_CYC7(23), .TMR_CYC7(37)
  ) u_dut (
    .MCLK(mclk),
    .RESET(reset),
    .HSEL(hsel),
    .HADDR(haddr),
    .HTRANS(htrans),
    .HWRITE(hwrite),
    .HSIZE(hsize),
    .HWDATA(hwdata),
    .HREADY(hreadyout),
    .HRDATA(hrdata),
    .HREADYOUT(hreadyout),
    .HRESP(hresp),
    .HOME_INPUT(home),
    .ZPHASE_INPUT(zph),
    .DEVIATION_CLEAR_OUT(dev_clr),
    .REAL_POS_CLEAR(real_clr),
    .LOGIC_POS_CLEAR(logic_clr),
    .SEARCH_BUSY(busy)
  );

  hsm2_sensor_model u_sens (
    .clk(mclk),
    .pol(pol),
    .dev_clr(dev_clr),
    .home(home),
    .zph(zph),
    .width(width_seen)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (real_clr === 1'b1 || logic_clr === 1'b1) begin
      clr_cnt <= clr_cnt + 1;
    end
  end

  // =====================================================
  // checking and bus access
  task automatic stop_test();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r);
    int i;
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= w;
    for (i = 0; i < 50; i++) begin
      @(posedge mclk);
      if (hreadyout === 1'b1) break;
    end
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    for (i = 0; i < 50; i++) begin
      @(posedge mclk);
      if (hreadyout === 1'b1) break;
    end
    r = hrdata;
  endtask : bus

  // =====================================================
  // search helpers
  task automatic cfg(input logic [15:0] st, input logic [1:0] ctl);
    bus(`HSM2_OFS_STAGING, 1'b1, {16'h0000, st}, q);
    bus(`HSM2_OFS_CONTROL, 1'b1, {30'h00000000, ctl}, q);
    bus(`HSM2_OFS_COMMAND, 1'b1, {24'h000000, `HSM2_CMD_MODE2}, q);
    // idle level follows the latched mode
    pol <= st[3];
  endtask : cfg

  task automatic start_search();
    bus(`HSM2_OFS_COMMAND, 1'b1, {24'h000000, `HSM2_CMD_SEARCH}, q);
    @(posedge mclk);
    chk("busy", {31'h00000000, busy}, 32'h1);
  endtask : start_search

  task automatic poll_state(input logic [31:0] exp);
    int i;
    for (i = 0; i < 60; i++) begin
      bus(`HSM2_OFS_STATUS, 1'b0, 32'h0, q);
      if (q === exp) break;
    end
    chk("state", q, exp);
  endtask : poll_state

  task automatic wait_pulse();
    int i;
    for (i = 0; i < 9000 && dev_clr === pol; i++) @(posedge mclk);
    for (i = 0; i < 9000 && dev_clr !== pol; i++) @(posedge mclk);
  endtask : wait_pulse

  function automatic int exp_width(input logic [2:0] c);
    case (c)
      3'h0: return 160;
      3'h1: return 320;
      3'h2: return 1600;
      3'h3: return 3200;
      default: return 16 + c;
    endcase
  endfunction : exp_width

  task automatic search(input logic [2:0] c);
    cfg({5'h00, {3{c[0]}}, c[0], c, c[1], c[2], c[0], 1'b0}, 2'b11);
    start_search();
    u_sens.drive(1'b1, 1'b0);
    wait_pulse();
    poll_state(32'h4);
    chk("width2", {8'h00, width_seen}, exp_width(c));
    u_sens.drive(1'b1, 1'b1);
    wait_pulse();
    for (n = 0; n < 100 && busy === 1'b1; n++) @(posedge mclk);
    // timer code 7 is 37 cycles, plus the finish cycle
    chk("timer", n, c[0] ? 32'h00000026 : 32'h00000001);
    chk("width3", {8'h00, width_seen}, exp_width(c));
    chk("real clear", {31'h00000000, real_clr}, {31'h00000000, c[0]});
    chk("logic clear", {31'h00000000, logic_clr}, {31'h00000000, c[2]});
    @(posedge mclk);
    chk("clears off", {30'h00000000, real_clr, logic_clr}, 32'h0);
    u_sens.drive(1'b0, 1'b0);
    $display("search test code %0d done", c);
  endtask : search

  // =====================================================
  // main sequence
  initial begin
    reset = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    pol = 1'b0;
    clr_cnt = 0;
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    poll_state(32'h1);
    bus(`HSM2_OFS_CONTROL, 1'b1, 32'h3, q);
    bus(`HSM2_OFS_CONTROL, 1'b0, 32'h0, q);
    chk("control", q, 32'h3);
    bus(`HSM2_OFS_STAGING, 1'b0, 32'h0, q);
    chk("staging", q, 32'h0);
    bus(8'h10, 1'b0, 32'h0, q);
    chk("unmapped", q, 32'h0);
    chk("resp", {31'h00000000, hresp}, 32'h0);
    chk("ready", {31'h00000000, hreadyout}, 32'h1);
    $display("register test done");
    for (k = 0; k < 8; k++) begin
      search(k[2:0]);
    end
    for (k = 0; k < 2; k++) begin
      cfg(16'h07FE, 2'b01);
      start_search();
      u_sens.drive(1'b1, 1'b0);
      wait_pulse();
      n = clr_cnt;
      bus(`HSM2_OFS_COMMAND, 1'b1,
          {24'h000000, k ? `HSM2_CMD_INST_STOP : `HSM2_CMD_DEC_STOP}, q);
      bus(`HSM2_OFS_STATUS, 1'b0, 32'h0, q);
      chk("abort idle", q, 32'h1);
      repeat (50) @(posedge mclk);
      // a search still running would now hit step 3 and finish
      u_sens.drive(1'b1, 1'b1);
      repeat (50) @(posedge mclk);
      chk("abort clears", clr_cnt, n);
      u_sens.drive(1'b0, 1'b0);
      $display("abort test %0d done", k);
    end
    cfg(16'h0001, 2'b00);
    start_search();
    u_sens.drive(1'b1, 1'b0);
    u_sens.drive(1'b0, 1'b0);
    u_sens.drive(1'b0, 1'b1);
    repeat (5) @(posedge mclk);
    poll_state(32'h4);
    u_sens.drive(1'b1, 1'b0);
    u_sens.drive(1'b1, 1'b1);
    poll_state(32'h1);
    $display("combined stop test done");
    stop_test();
  end

  initial begin
    repeat (60000) @(posedge mclk);
    failures++;
    stop_test();
  end
endmodule : home_search_mode2_config_tb_top
`default_nettype wire

// >>> hsm2_countdown.sv
// hsm2_countdown.sv: cycle countdown for clear pulse and step timer
// assumes: one clock, synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
`include "hsm2_defs.svh"

module hsm2_countdown (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic cancel,
  input wire logic [`HSM2_CNT_W-1:0] load,
  output logic busy,
  output logic done
);

  logic [`HSM2_CNT_W-1:0] cnt_r;
  logic [`HSM2_CNT_W-1:0] cnt_nxt;

  // =====================================================
  // busy for exactly load cycles, done in the last one
  always_comb begin
    cnt_nxt = cnt_r;
    if (cancel) begin
      cnt_nxt = '0;
    end else if (start) begin
      cnt_nxt = load;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - `HSM2_CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign busy = (cnt_r != '0);
  assign done = (cnt_r == `HSM2_CNT_W'(1));

endmodule : hsm2_countdown
`default_nettype wire

// >>> hsm2_defs.svh
// hsm2_defs.svh: offsets, field positions, reset values and timing figures
// assumes: included by bare name; definitions only
`ifndef HSM2_DEFS_SVH
`define HSM2_DEFS_SVH

// =====================================================
// register byte offsets
`define HSM2_OFS_STAGING 8'h00
`define HSM2_OFS_COMMAND 8'h04
`define HSM2_OFS_STATUS 8'h08
`define HSM2_OFS_CONTROL 8'h0C

// =====================================================
// command codes
`define HSM2_CMD_MODE2 8'h24
`define HSM2_CMD_SEARCH 8'h5A
`define HSM2_CMD_DEC_STOP 8'h56
`define HSM2_CMD_INST_STOP 8'h57

// =====================================================
// fields and reset values
`define HSM2_MODE2_RESET 16'h0000
`define HSM2_STAGING_RESET 16'h0000
`define HSM2_CONTROL_RESET 2'h0
`define HSM2_CTL_DCC_STEP2 0
`define HSM2_CTL_DCC_STEP3 1

// =====================================================
// timing: reference clock, pulse widths in us, timer in ms
`define HSM2_REF_MHZ 16
`define HSM2_REF_KHZ 16000
`define HSM2_CLR_T0_US 10
`define HSM2_CLR_T1_US 20
`define HSM2_CLR_T2_US 100
`define HSM2_CLR_T3_US 200
`define HSM2_CLR_T4_US 1000
`define HSM2_CLR_T5_US 2000
`define HSM2_CLR_T6_US 10000
`define HSM2_CLR_T7_US 20000
`define HSM2_TMR_T0_MS 1
`define HSM2_TMR_T1_MS 2
`define HSM2_TMR_T2_MS 10
`define HSM2_TMR_T3_MS 20
`define HSM2_TMR_T4_MS 100
`define HSM2_TMR_T5_MS 200
`define HSM2_TMR_T6_MS 500
`define HSM2_TMR_T7_MS 1000
`define HSM2_CLR_CYC0 (`HSM2_CLR_T0_US * `HSM2_REF_MHZ)
`define HSM2_CLR_CYC1 (`HSM2_CLR_T1_US * `HSM2_REF_MHZ)
`define HSM2_CLR_CYC2 (`HSM2_CLR_T2_US * `HSM2_REF_MHZ)
`define HSM2_CLR_CYC3 (`HSM2_CLR_T3_US * `HSM2_REF_MHZ)
`define HSM2_CNT_W 24

`endif

// >>> hsm2_pkg.sv
// hsm2_pkg.sv: types of the home search mode two block
// assumes: nothing
package hsm2_pkg;

  // =====================================================
  // mode set two as latched from the staging word
  typedef struct packed {
    logic [4:0] unused;
    logic [2:0] step_timer_sel;
    logic step_timer_enable;
    logic [2:0] clear_pulse_width;
    logic clear_pulse_polarity;
    logic logic_pos_clear_at_end;
    logic real_pos_clear_at_end;
    logic home_and_zphase_stop;
  } hsm2_mode_type;

  // =====================================================
  // search sequencer states
  typedef enum logic [5:0] {
    HSM2_IDLE = 6'b000001,
    HSM2_SRCH2 = 6'b000010,
    HSM2_SRCH3 = 6'b000100,
    HSM2_PULSE = 6'b001000,
    HSM2_WAIT = 6'b010000,
    HSM2_FINISH = 6'b100000
  } hsm2_state_type;

endpackage : hsm2_pkg

// >>> hsm2_sensor_model.sv
// hsm2_sensor_model.sv: home and z-phase sensors, receiver of the deviation clear pulse
// assumes: one clock; sensor levels change only through drive
`timescale 1ns/100ps
`default_nettype none

module hsm2_sensor_model (
  input wire logic clk,
  input wire logic pol,
  input wire logic dev_clr,
  output logic home,
  output logic zph,
  output logic [23:0] width
);
  logic [23:0] run;

  initial begin
    home = 1'b0;
    zph = 1'b0;
    width = 24'h000000;
    run = 24'h000000;
  end

  // =====================================================
  // sensor levels, changed just after an edge
  task automatic drive(input logic h, input logic z);
    @(posedge clk);
    home <= h;
    zph <= z;
  endtask : drive

  // =====================================================
  // active length in clocks; active level is opposite to pol
  always @(posedge clk) begin
    if (dev_clr !== pol) begin
      run <= run + 24'h000001;
    end else if (run != 24'h000000) begin
      width <= run;
      run <= 24'h000000;
    end
  end
endmodule : hsm2_sensor_model
`default_nettype wire

// >>> hsm2_top.sv
// hsm2_top.sv: home search mode set two, search start and stop, AHB-Lite slave
// assumes: single AHB-Lite master, word transfers, sensor inputs synchronous
// Notes on behaviour
// RULE1 - the clear pulse is high-going when the polarity bit is 0, low-going when 1.
// RULE2 - the width code 0..7 picks 10, 20, 100, 200 us, 1, 2, 10, 20 ms at 16 MHz.
// RULE3 - the between-step wait is inserted only when the timer enable bit is 1.
// RULE4 - the timer code 0..7 picks 1, 2, 10, 20, 100, 200, 500, 1000 ms at 16 MHz.
// RULE5 - with the real clear bit set, the real position counter clears at search end.
// RULE6 - with the logical clear bit set, the logical position counter clears at search end.
// RULE7 - with the combined stop bit set, step 3 stops only on Z-phase rising while home is on.
// RULE8 - software sets the combined stop bit only when home is the step 2 signal.
// RULE9 - command 5Ah starts the search sequence after the modes are set.
// RULE10 - command 24h latches the staging word as mode set two.
// RULE11 - commands 56h and 57h abort the search and cancel a running timer.
// RULE12 - widths and waits are counted in system clock cycles scaled to 16 MHz.
`timescale 1ns/100ps
`default_nettype none
`include "hsm2_defs.svh"

module hsm2_top #(
  parameter int unsigned CLR_CYC4 = `HSM2_CLR_T4_US * `HSM2_REF_MHZ,
  parameter int unsigned CLR_CYC5 = `HSM2_CLR_T5_US * `HSM2_REF_MHZ,
  parameter int unsigned CLR_CYC6 = `HSM2_CLR_T6_US * `HSM2_REF_MHZ,
  parameter int unsigned CLR_CYC7 = `HSM2_CLR_T7_US * `HSM2_REF_MHZ,
  parameter int unsigned TMR_CYC0 = `HSM2_TMR_T0_MS * `HSM2_REF_KHZ,
  parameter int unsigned TMR_CYC1 = `HSM2_TMR_T1_MS * `HSM2_REF_KHZ,
  parameter int unsigned TMR_CYC2 = `HSM2_TMR_T2_MS * `HSM2_REF_KHZ,
  parameter int unsigned TMR_CYC3 = `HSM2_TMR_T3_MS * `HSM2_REF_KHZ,
  parameter int unsigned TMR_CYC4 = `HSM2_TMR_T4_MS * `HSM2_REF_KHZ,
  parameter int unsigned TMR_CYC5 = `HSM2_TMR_T5_MS * `HSM2_REF_KHZ,
  parameter int unsigned TMR_CYC6 = `HSM2_TMR_T6_MS * `HSM2_REF_KHZ,
  parameter int unsigned TMR_CYC7 = `HSM2_TMR_T7_MS * `HSM2_REF_KHZ
) (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic HOME_INPUT,
  input wire logic ZPHASE_INPUT,
  output logic DEVIATION_CLEAR_OUT,
  output logic REAL_POS_CLEAR,
  output logic LOGIC_POS_CLEAR,
  output logic SEARCH_BUSY
);

  // =====================================================
  // count selection
  function automatic logic [`HSM2_CNT_W-1:0] clr_cycles(input logic [2:0] sel);
    int unsigned v;
    unique case (sel)
      3'h0: v = `HSM2_CLR_CYC0;
      3'h1: v = `HSM2_CLR_CYC1;
      3'h2: v = `HSM2_CLR_CYC2;
      3'h3: v = `HSM2_CLR_CYC3;
      3'h4: v = CLR_CYC4;
      3'h5: v = CLR_CYC5;
      3'h6: v = CLR_CYC6;
      3'h7: v = CLR_CYC7;
    endcase
    return v[`HSM2_CNT_W-1:0];
  endfunction : clr_cycles

  function automatic logic [`HSM2_CNT_W-1:0] tmr_cycles(input logic [2:0] sel);
    int unsigned v;
    unique case (sel)
      3'h0: v = TMR_CYC0;
      3'h1: v = TMR_CYC1;
      3'h2: v = TMR_CYC2;
      3'h3: v = TMR_CYC3;
      3'h4: v = TMR_CYC4;
      3'h5: v = TMR_CYC5;
      3'h6: v = TMR_CYC6;
      3'h7: v = TMR_CYC7;
    endcase
    return v[`HSM2_CNT_W-1:0];
  endfunction : tmr_cycles

  // =====================================================
  // bus slave
  logic wr_pend_r;
  logic wr_pend_nxt;
  logic [7:0] wr_addr_r;
  logic [7:0] wr_addr_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [15:0] staging_r;
  logic [15:0] staging_nxt;
  logic [1:0] control_r;
  logic [1:0] control_nxt;
  hsm2_pkg::hsm2_mode_type mode_r;
  hsm2_pkg::hsm2_mode_type mode_nxt;
  hsm2_pkg::hsm2_state_type state_r;
  hsm2_pkg::hsm2_state_type state_nxt;
  logic addr_ok;
  logic cmd_wr;
  logic cmd_start;
  logic cmd_abort;

  assign addr_ok = HSEL && HREADY && HTRANS[1];
  assign cmd_wr = wr_pend_r && (wr_addr_r == `HSM2_OFS_COMMAND);
  assign cmd_start = cmd_wr && (HWDATA[7:0] == `HSM2_CMD_SEARCH);
  assign cmd_abort = cmd_wr && ((HWDATA[7:0] == `HSM2_CMD_DEC_STOP)
                    || (HWDATA[7:0] == `HSM2_CMD_INST_STOP));

  always_comb begin
    wr_pend_nxt = addr_ok && HWRITE;
    wr_addr_nxt = addr_ok ? HADDR[7:0] : wr_addr_r;
    rdata_nxt = 32'h00000000;
    if (addr_ok && !HWRITE) begin
      unique case (HADDR[7:0])
        `HSM2_OFS_STATUS: rdata_nxt = {26'h0000000, state_r};
        `HSM2_OFS_CONTROL: rdata_nxt = {30'h00000000, control_r};
        default: rdata_nxt = 32'h00000000;
      endcase
    end
    staging_nxt = staging_r;
    control_nxt = control_r;
    mode_nxt = mode_r;
    if (wr_pend_r && wr_addr_r == `HSM2_OFS_STAGING) begin
      staging_nxt = HWDATA[15:0];
    end
    if (wr_pend_r && wr_addr_r == `HSM2_OFS_CONTROL) begin
      control_nxt = HWDATA[1:0];
    end
    if (cmd_wr && HWDATA[7:0] == `HSM2_CMD_MODE2) begin
      mode_nxt = hsm2_pkg::hsm2_mode_type'(staging_r); // see RULE10
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      rdata_r <= 32'h00000000;
      staging_r <= `HSM2_STAGING_RESET;
      control_r <= `HSM2_CONTROL_RESET;
      mode_r <= hsm2_pkg::hsm2_mode_type'(`HSM2_MODE2_RESET);
    end else begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      rdata_r <= rdata_nxt;
      staging_r <= staging_nxt;
      control_r <= control_nxt;
      mode_r <= mode_nxt;
    end
  end

  assign HRDATA = rdata_r;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  // =====================================================
  // search sequencer
  logic step3_r;
  logic step3_nxt;
  logic home_prev_r;
  logic z_prev_r;
  logic dcc_r;
  logic real_r;
  logic logic_r;
  logic cnt_start;
  logic [`HSM2_CNT_W-1:0] cnt_load;
  logic cnt_done;
  logic cnt_busy;
  logic step_hit;
  logic advance;

  hsm2_countdown u_count (
    .clk(MCLK),
    .rst(RESET),
    .start(cnt_start),
    .cancel(cmd_abort),
    .load(cnt_load),
    .busy(cnt_busy),
    .done(cnt_done)
  );

  always_comb begin
    state_nxt = state_r;
    step3_nxt = step3_r;
    cnt_start = 1'b0;
    cnt_load = clr_cycles(mode_r.clear_pulse_width); // see RULE2 see RULE12
    step_hit = 1'b0;
    advance = 1'b0;
    unique case (state_r)
      hsm2_pkg::HSM2_IDLE: begin
        if (cmd_start) begin
          state_nxt = hsm2_pkg::HSM2_SRCH2; // see RULE9
          step3_nxt = 1'b0;
        end
      end
      hsm2_pkg::HSM2_SRCH2: begin
        step_hit = HOME_INPUT && !home_prev_r;
      end
      hsm2_pkg::HSM2_SRCH3: begin
        step_hit = ZPHASE_INPUT && !z_prev_r
          && (!mode_r.home_and_zphase_stop || HOME_INPUT); // see RULE7
      end
      hsm2_pkg::HSM2_PULSE: begin
        advance = cnt_done;
      end
      hsm2_pkg::HSM2_WAIT: begin
        if (cnt_done) begin
          state_nxt = step3_r ? hsm2_pkg::HSM2_FINISH : hsm2_pkg::HSM2_SRCH3;
          step3_nxt = 1'b1;
        end
      end
      hsm2_pkg::HSM2_FINISH: begin
        state_nxt = hsm2_pkg::HSM2_IDLE;
      end
    endcase
    if (step_hit) begin
      if (control_r[step3_r ? `HSM2_CTL_DCC_STEP3 : `HSM2_CTL_DCC_STEP2]) begin
        state_nxt = hsm2_pkg::HSM2_PULSE;
        cnt_start = 1'b1;
      end else begin
        advance = 1'b1;
      end
    end
    if (advance) begin
      if (mode_r.step_timer_enable) begin // see RULE3
        state_nxt = hsm2_pkg::HSM2_WAIT;
        cnt_start = 1'b1;
        cnt_load = tmr_cycles(mode_r.step_timer_sel); // see RULE4 see RULE12
      end else begin
        state_nxt = step3_r ? hsm2_pkg::HSM2_FINISH : hsm2_pkg::HSM2_SRCH3;
        step3_nxt = 1'b1;
      end
    end
    if (cmd_abort && state_r != hsm2_pkg::HSM2_IDLE) begin
      state_nxt = hsm2_pkg::HSM2_IDLE; // see RULE11
      cnt_start = 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      state_r <= hsm2_pkg::HSM2_IDLE;
      step3_r <= 1'b0;
      home_prev_r <= 1'b0;
      z_prev_r <= 1'b0;
      dcc_r <= 1'b0;
      real_r <= 1'b0;
      logic_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      step3_r <= step3_nxt;
      home_prev_r <= HOME_INPUT;
      z_prev_r <= ZPHASE_INPUT;
      dcc_r <= (state_nxt == hsm2_pkg::HSM2_PULSE) ^ mode_nxt.clear_pulse_polarity; // see RULE1
      real_r <= (state_r == hsm2_pkg::HSM2_FINISH) && mode_r.real_pos_clear_at_end; // see RULE5
      logic_r <= (state_r == hsm2_pkg::HSM2_FINISH) && mode_r.logic_pos_clear_at_end; // see RULE6
    end
  end

  assign DEVIATION_CLEAR_OUT = dcc_r;
  assign REAL_POS_CLEAR = real_r;
  assign LOGIC_POS_CLEAR = logic_r;
  assign SEARCH_BUSY = (state_r != hsm2_pkg::HSM2_IDLE);

  // =====================================================
  // checks
  logic [`HSM2_CNT_W-1:0] len_r;
  always_ff @(posedge MCLK) begin
    if (RESET || state_nxt != state_r) begin
      len_r <= '0;
    end else begin
      len_r <= len_r + `HSM2_CNT_W'(1);
    end
  end

  property p_dcc_level;
    @(posedge MCLK) disable iff (RESET)
      state_r == hsm2_pkg::HSM2_PULSE |-> DEVIATION_CLEAR_OUT != mode_r.clear_pulse_polarity;
  endproperty
  a_dcc_level: assert property (p_dcc_level) else $error("clear pulse level wrong"); // see RULE1

  property p_pulse_len;
    @(posedge MCLK) disable iff (RESET)
      (state_r == hsm2_pkg::HSM2_PULSE && state_nxt != state_r && !cmd_abort)
      |-> len_r == clr_cycles(mode_r.clear_pulse_width) - `HSM2_CNT_W'(1);
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("clear pulse width wrong"); // see RULE2

  property p_no_wait;
    @(posedge MCLK) disable iff (RESET)
      !mode_r.step_timer_enable && state_r != hsm2_pkg::HSM2_WAIT
      |=> state_r != hsm2_pkg::HSM2_WAIT;
  endproperty
  a_no_wait: assert property (p_no_wait) else $error("wait without timer enable"); // see RULE3

  property p_wait_len;
    @(posedge MCLK) disable iff (RESET)
      (state_r == hsm2_pkg::HSM2_WAIT && state_nxt != state_r && !cmd_abort)
      |-> len_r == tmr_cycles(mode_r.step_timer_sel) - `HSM2_CNT_W'(1);
  endproperty
  a_wait_len: assert property (p_wait_len) else $error("step timer length wrong"); // see RULE4

  property p_real_clr;
    @(posedge MCLK) disable iff (RESET)
      state_r == hsm2_pkg::HSM2_FINISH |=> REAL_POS_CLEAR == $past(mode_r.real_pos_clear_at_end);
  endproperty
  a_real_clr: assert property (p_real_clr) else $error("real clear wrong"); // see RULE5

  property p_logic_clr;
    @(posedge MCLK) disable iff (RESET)
      LOGIC_POS_CLEAR |-> $past(state_r) == hsm2_pkg::HSM2_FINISH
        && $past(mode_r.logic_pos_clear_at_end);
  endproperty
  a_logic_clr: assert property (p_logic_clr) else $error("logical clear wrong"); // see RULE6

  property p_and_stop;
    @(posedge MCLK) disable iff (RESET)
      state_r == hsm2_pkg::HSM2_SRCH3 && mode_r.home_and_zphase_stop && !HOME_INPUT && !cmd_abort
      |=> state_r == hsm2_pkg::HSM2_SRCH3;
  endproperty
  a_and_stop: assert property (p_and_stop) else $error("step three left without home"); // see RULE7

  property p_start;
    @(posedge MCLK) disable iff (RESET)
      cmd_start && state_r == hsm2_pkg::HSM2_IDLE |=> state_r == hsm2_pkg::HSM2_SRCH2 ##0 SEARCH_BUSY;
  endproperty
  a_start: assert property (p_start) else $error("search did not start"); // see RULE9

  property p_latch;
    @(posedge MCLK) disable iff (RESET)
      cmd_wr && HWDATA[7:0] == `HSM2_CMD_MODE2 |=> mode_r == $past(staging_r);
  endproperty
  a_latch: assert property (p_latch) else $error("mode set not latched"); // see RULE10

  property p_abort;
    @(posedge MCLK) disable iff (RESET)
      cmd_abort |=> !SEARCH_BUSY && !cnt_busy;
  endproperty
  a_abort: assert property (p_abort) else $error("stop did not end search"); // see RULE11

  c_pulse: cover property (@(posedge MCLK) disable iff (RESET)
    state_r == hsm2_pkg::HSM2_PULSE ##1 state_r == hsm2_pkg::HSM2_WAIT);
  c_finish: cover property (@(posedge MCLK) disable iff (RESET)
    state_r == hsm2_pkg::HSM2_FINISH ##1 REAL_POS_CLEAR && LOGIC_POS_CLEAR);
  c_abort_wait: cover property (@(posedge MCLK) disable iff (RESET)
    state_r == hsm2_pkg::HSM2_WAIT && cmd_abort);

endmodule : hsm2_top
`default_nettype wire
